// ### design/brs_selftest_ctrl.sv
// Notes on behaviour
// [R1] Command nibble 1011 requests one internal register byte.
// [R2] Commands whose device address differs from ours are silently dropped.
// [R3] Low data nibble of a register read selects the byte to return.
// [R4] Read reply: device address, echoed byte address, register byte; CRC follows.
// [R5] Command nibble 1100 turns self-test off.
// [R6] Self-test off accepted in standard and enhanced, long and short framing.
// [R7] Self-test off data byte only matters for the CRC check.
// [R8] Self-test off to global address 0000 is executed without reply.
// [R9] Self-test off removes the test plate stimulus.
// [R10] Short off reply: bits 14..8 zero, then status byte.
// [R11] Long off reply: address, four zeros, same status byte.
// [R12] Internal error bit is 1 when a fault was detected.
// [R13] Attribute bits come from the first configuration register.
// [R14] Bus switch bit is 1 when the downstream switch is to close.
// [R15] Self-test bit is 1 while self-test circuitry is active.
// [R16] Undervoltage bit is set while holdup capacitor voltage is low.
// [R17] OTP bit is 1 while user OTP programming is enabled.
// [R18] Two self-test off commands in direct succession lock self-test out.
// [R19] Lockout keeps self-test off until undervoltage, Clear or a reset event.
// [R20] Register read only in long framing and never to global address.
// [R21] While locked, self-test on is refused and status bit reads zero.
// [R22] Nibble 1101 turns self-test on and restarts the off count.
// [R23] Any other accepted command between two off commands restarts the count.
`timescale 1ns/1ps
`default_nettype none
module brs_selftest_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Decoded bus commands and device conditions
  input  wire brs_pkg::brs_cmd_s    cmd,
  input  wire brs_pkg::brs_env_s    env,
  // Replies and self-test control
  output var brs_pkg::brs_resp_s    resp,
  output logic                      plate_drive,
  output logic                      lockout
);

  typedef struct packed {
    brs_pkg::brs_lock_e  lock;
    logic                selftest;
    logic                locked;
    logic [31:0]         ctrl;
    logic [15:0][7:0]    regf;
    logic                aw_full;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_full;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    brs_pkg::brs_resp_s  resp;
  } brs_state_s;

  brs_state_s st;
  brs_state_s next_st;

  logic [3:0] dev_addr;
  logic       enh_en;
  logic       frame_ok;
  logic       to_us;
  logic       to_global;
  logic       read_acc;
  logic       off_acc;
  logic       on_acc;
  logic       other_acc;
  logic       lock_clear;
  logic [7:0] stat_byte;
  logic       off_pending;

  // Word-aligned decode; low address bits are ignored
  function automatic brs_pkg::brs_sel_e decode(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == brs_pkg::CTRL_OFF) begin
      return brs_pkg::SEL_CTRL;
    end else if (w == brs_pkg::STAT_OFF) begin
      return brs_pkg::SEL_STAT;
    end else if (w >= brs_pkg::REGF_BASE && w <= brs_pkg::REGF_LAST) begin
      return brs_pkg::SEL_REGF;
    end
    return brs_pkg::SEL_NONE;
  endfunction : decode

  // Status byte shared by both self-test off reply framings
  function automatic logic [7:0] status_of(input brs_pkg::brs_env_s e,
                                           input logic st_on,
                                           input logic [1:0] attr);
    return {e.otp_program_enabled_flag,   // [R17]
            e.holdup_uv,                  // [R16]
            st_on,                        // [R15]
            e.bus_switch_close_flag,      // [R14]
            attr,                         // [R13]
            e.internal_error,             // [R12]
            1'b0};
  endfunction : status_of

  assign dev_addr  = st.ctrl[brs_pkg::CTRL_ADDR_LSB +: 4];
  assign enh_en    = st.ctrl[brs_pkg::CTRL_ENH_BIT];
  // Enhanced framing only counts once software has enabled it
  assign frame_ok  = cmd.valid && cmd.crc_ok && (!cmd.enhanced || enh_en); // [R6] [R7]
  assign to_us     = frame_ok && (cmd.addr == dev_addr)
                     && (cmd.addr != brs_pkg::GLOBAL_ADDR); // [R2]
  assign to_global = frame_ok && (cmd.addr == brs_pkg::GLOBAL_ADDR);
  assign read_acc  = to_us && cmd.is_long && (cmd.code == brs_pkg::CMD_READ_REG); // [R1] [R20]
  assign off_acc   = (to_us || to_global) && (cmd.code == brs_pkg::CMD_SELFTEST_OFF); // [R5] [R8]
  assign on_acc    = to_us && (cmd.code == brs_pkg::CMD_SELFTEST_ON); // [R22]
  assign other_acc = to_us && (cmd.code != brs_pkg::CMD_READ_REG)
                     && (cmd.code != brs_pkg::CMD_SELFTEST_OFF)
                     && (cmd.code != brs_pkg::CMD_SELFTEST_ON); // [R23]
  assign lock_clear = env.holdup_uv || env.clear_cmd || env.regulator_uv_reset
                      || env.frame_timeout_reset; // [R19]
  // Self-test is reported as already removed in the off reply
  assign stat_byte = status_of(env, 1'b0,
                               st.regf[brs_pkg::CFG1_IDX][brs_pkg::ATTR_LSB +: 2]);
  // One off command seen, a second one locks
  assign off_pending = (st.lock == brs_pkg::LK_ONE_OFF);

  always_comb begin
    brs_pkg::brs_sel_e wsel;
    brs_pkg::brs_sel_e rsel;
    brs_pkg::brs_lock_e base;
    logic [31:0] wmask;
    wsel  = decode(st.aw_addr);
    rsel  = decode(s_axi_araddr);
    base  = lock_clear ? brs_pkg::LK_IDLE : st.lock;
    wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
    next_st = st;
    next_st.resp.valid = 1'b0;

    // Register read reply
    if (read_acc) begin
      next_st.resp.valid   = 1'b1;
      next_st.resp.is_long = 1'b1;
      next_st.resp.data    = {cmd.addr, cmd.data[3:0], st.regf[cmd.data[3:0]]}; // [R3] [R4]
    end

    // Self-test off; broadcast form is silent
    if (off_acc) begin
      next_st.selftest = 1'b0; // [R9]
      if (to_us) begin
        next_st.resp.valid   = 1'b1;
        next_st.resp.is_long = cmd.is_long;
        next_st.resp.data    = cmd.is_long ? {cmd.addr, 4'h0, stat_byte} // [R11]
                                           : {8'h00, stat_byte};         // [R10]
      end
    end

    if (on_acc && st.lock != brs_pkg::LK_LOCKED) begin
      next_st.selftest = 1'b1; // [R21]
    end

    // Lockout tracker; a second off wins over a same-cycle clear event
    if (off_acc) begin
      case (st.lock)
        brs_pkg::LK_IDLE:    next_st.lock = brs_pkg::LK_ONE_OFF;
        brs_pkg::LK_ONE_OFF: next_st.lock = brs_pkg::LK_LOCKED; // [R18]
        brs_pkg::LK_LOCKED:  next_st.lock = brs_pkg::LK_LOCKED;
        default:             next_st.lock = brs_pkg::LK_IDLE;
      endcase
    end else if (read_acc || on_acc || other_acc) begin
      next_st.lock = (base == brs_pkg::LK_LOCKED) ? brs_pkg::LK_LOCKED
                                                  : brs_pkg::LK_IDLE; // [R22] [R23]
    end else begin
      next_st.lock = base; // [R19]
    end
    if (next_st.lock == brs_pkg::LK_LOCKED) begin
      next_st.selftest = 1'b0; // [R19] [R21]
    end
    next_st.locked = (next_st.lock == brs_pkg::LK_LOCKED);

    // Write response retires before a new write can complete
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_full && st.w_full) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = brs_pkg::RESP_OKAY;
      case (wsel)
        brs_pkg::SEL_CTRL: begin
          next_st.ctrl = (st.ctrl & ~(wmask & brs_pkg::CTRL_WR_MASK))
                         | (st.w_data & wmask & brs_pkg::CTRL_WR_MASK);
        end
        brs_pkg::SEL_REGF: begin
          if (st.w_strb[0]) begin
            next_st.regf[st.aw_addr[5:2]] = st.w_data[7:0];
          end
        end
        brs_pkg::SEL_STAT: begin
          next_st.bresp = brs_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = brs_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready  = !next_st.w_full && !next_st.bvalid;

    // Read channel, one outstanding read
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = brs_pkg::RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      case (rsel)
        brs_pkg::SEL_CTRL: next_st.rdata = st.ctrl;
        brs_pkg::SEL_STAT: begin
          next_st.rdata[brs_pkg::STAT_ST_BIT]      = st.selftest;
          next_st.rdata[brs_pkg::STAT_LOCK_BIT]    = (st.lock == brs_pkg::LK_LOCKED);
          next_st.rdata[brs_pkg::STAT_PENDING_BIT] = (st.lock == brs_pkg::LK_ONE_OFF);
        end
        brs_pkg::SEL_REGF: next_st.rdata[7:0] = st.regf[s_axi_araddr[5:2]];
        default:           next_st.rresp = brs_pkg::RESP_SLVERR;
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.lock     <= brs_pkg::LK_IDLE;
      st.ctrl     <= brs_pkg::CTRL_RST;
      st.regf     <= {16{brs_pkg::REGF_RST}};
      st.awready  <= 1'b1;
      st.wready   <= 1'b1;
      st.arready  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign resp          = st.resp;
  assign plate_drive   = st.selftest;
  assign lockout       = st.locked;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  read_reply_word_a: assert property ( // [R4]
    read_acc |=> resp.valid && resp.is_long
      && resp.data[15:8] == {$past(cmd.addr), $past(cmd.data[3:0])})
    else $error("Register read reply header wrong");

  read_short_drop_a: assert property ( // [R20]
    cmd.valid && cmd.code == brs_pkg::CMD_READ_REG && !cmd.is_long |=> !resp.valid)
    else $error("Short register read was answered");

  foreign_addr_drop_a: assert property ( // [R2]
    cmd.valid && cmd.addr != dev_addr && cmd.addr != brs_pkg::GLOBAL_ADDR
      |=> !resp.valid && $stable(plate_drive))
    else $error("Foreign command had an effect");

  global_off_silent_a: assert property ( // [R8]
    off_acc && to_global |=> !resp.valid && !plate_drive)
    else $error("Broadcast off answered or not executed");

  off_short_reply_a: assert property ( // [R10]
    off_acc && to_us && !cmd.is_long
      |=> resp.valid && resp.data[15:8] == 8'h00 && !resp.data[0])
    else $error("Short off reply layout wrong");

  off_long_reply_a: assert property ( // [R11]
    off_acc && to_us && cmd.is_long
      |=> resp.data[15:12] == $past(cmd.addr) && resp.data[11:8] == 4'h0)
    else $error("Long off reply layout wrong");

  status_bits_a: assert property ( // [R13]
    off_acc && to_us |=> resp.data[7:1] == {$past(env.otp_program_enabled_flag),
      $past(env.holdup_uv), 1'b0, $past(env.bus_switch_close_flag),
      $past(st.regf[brs_pkg::CFG1_IDX][1:0]), $past(env.internal_error)})
    else $error("Off reply status byte wrong");

  two_off_lock_a: assert property ( // [R18]
    off_acc && off_pending |=> lockout && !plate_drive)
    else $error("Two successive off commands did not lock");

  locked_no_drive_a: assert property ( // [R19]
    lockout |-> !plate_drive)
    else $error("Self-test driven while locked");

  on_refused_a: assert property ( // [R21]
    lockout && on_acc && !lock_clear |=> !plate_drive [*2])
    else $error("Self-test on accepted while locked");

  on_breaks_count_a: assert property ( // [R23]
    (read_acc || on_acc || other_acc) && !lockout |=> !lockout && !off_pending)
    else $error("Intervening command did not restart count");

  clear_unlocks_a: assert property ( // [R19]
    lock_clear && !off_acc |=> !lockout && !off_pending)
    else $error("Clear event did not end lockout");

  off_removes_plate_a: assert property ( // [R9]
    off_acc |=> !plate_drive)
    else $error("Self-test off left plate driven");

  on_drives_plate_a: assert property ( // [R22]
    on_acc && !lockout |=> plate_drive)
    else $error("Self-test on not applied while unlocked");

  read_data_byte_a: assert property ( // [R3]
    read_acc |=> resp.data[7:0] == $past(st.regf[cmd.data[3:0]]))
    else $error("Register read returned wrong byte");

  crc_fail_drop_a: assert property ( // [R7]
    cmd.valid && !cmd.crc_ok |=> !resp.valid && $stable(plate_drive))
    else $error("Frame with bad CRC had an effect");

  enh_gate_a: assert property ( // [R6]
    cmd.valid && cmd.enhanced && !enh_en |=> !resp.valid && $stable(plate_drive))
    else $error("Enhanced frame used while disabled");

  global_read_drop_a: assert property ( // [R20]
    cmd.valid && cmd.code == brs_pkg::CMD_READ_REG && cmd.addr == brs_pkg::GLOBAL_ADDR
      |=> !resp.valid)
    else $error("Broadcast register read was answered");

  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer not given next cycle");

endmodule : brs_selftest_ctrl
`default_nettype wire

// ### design/brs_pkg.sv
`default_nettype none
package brs_pkg;

  // Command nibbles and the broadcast device address
  localparam logic [3:0] CMD_READ_REG     = 4'hB;
  localparam logic [3:0] CMD_SELFTEST_OFF = 4'hC;
  localparam logic [3:0] CMD_SELFTEST_ON  = 4'hD;
  localparam logic [3:0] GLOBAL_ADDR      = 4'h0;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STAT_OFF   = 8'h04;
  localparam logic [7:0] REGF_BASE  = 8'h40;
  localparam logic [7:0] REGF_LAST  = 8'h7C;

  // Control word fields and reset value
  localparam int          CTRL_ADDR_LSB = 0;
  localparam int          CTRL_ENH_BIT  = 4;
  localparam logic [31:0] CTRL_WR_MASK  = 32'h0000_001F;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;

  // Status word fields
  localparam int STAT_ST_BIT      = 0;
  localparam int STAT_LOCK_BIT    = 1;
  localparam int STAT_PENDING_BIT = 2;

  // Readable byte that holds the attribute field
  localparam logic [3:0] CFG1_IDX = 4'h1;
  localparam int         ATTR_LSB = 0;
  localparam logic [7:0] REGF_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    LK_IDLE    = 3'b001,
    LK_ONE_OFF = 3'b010,
    LK_LOCKED  = 3'b100
  } brs_lock_e;

  typedef enum logic [3:0] {
    SEL_CTRL = 4'b0001,
    SEL_STAT = 4'b0010,
    SEL_REGF = 4'b0100,
    SEL_NONE = 4'b1000
  } brs_sel_e;

  // One decoded bus command, valid for one cycle
  typedef struct packed {
    logic       valid;
    logic       is_long;
    logic       enhanced;
    logic       crc_ok;
    logic [7:0] data;
    logic [3:0] addr;
    logic [3:0] code;
  } brs_cmd_s;

  // Reply word handed to the bus transmitter, valid for one cycle
  typedef struct packed {
    logic        valid;
    logic        is_long;
    logic [15:0] data;
  } brs_resp_s;

  // Device state seen by the reply and by the lockout
  typedef struct packed {
    logic otp_program_enabled_flag;
    logic holdup_uv;
    logic bus_switch_close_flag;
    logic internal_error;
    logic clear_cmd;
    logic regulator_uv_reset;
    logic frame_timeout_reset;
  } brs_env_s;

endpackage : brs_pkg
`default_nettype wire

// ### tb/brs_dsi_master.sv
`timescale 1ns/1ps
`default_nettype none
module brs_dsi_master (
  // Clock
  input  wire logic              aclk,
  // Decoded frame towards the device
  output var brs_pkg::brs_cmd_s  cmd
);
  initial cmd = '0;

  // Frame lives one cycle; fields then toggle so a stale frame never looks valid
  task automatic send(input brs_pkg::brs_cmd_s c);
    brs_pkg::brs_cmd_s idle;
    idle       = ~c;
    idle.valid = 1'b0;
    @(posedge aclk);
    cmd <= c;
    @(posedge aclk);
    cmd <= idle;
  endtask : send
endmodule : brs_dsi_master
`default_nettype wire

// ### tb/tb_bus_register_read_and_selftest_off.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_register_read_and_selftest_off;
  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, plate, lock;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, w;
  logic [3:0]         wstrb;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  brs_pkg::brs_cmd_s  cmd;
  brs_pkg::brs_env_s  env;
  brs_pkg::brs_resp_s resp;
  int                 errors, checks, dev, pend, i;
  logic               enh, st, uv;
  logic [7:0]         regf [16];

  brs_selftest_ctrl #(.ADDR_W(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd(cmd), .env(env), .resp(resp), .plate_drive(plate), .lockout(lock)
  );
  brs_dsi_master i_mst (.aclk(aclk), .cmd(cmd));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end
    else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk(bresp, er);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask : axr

  function automatic logic [31:0] stat();
    return {29'h0, pend == 1, pend == 2, st};
  endfunction : stat

  // Sends one frame and predicts reply, plate and lockout from the rules
  task automatic dsi(input logic [3:0] code, input logic [3:0] a, input logic [7:0] d,
                     input logic lng, input logic en, input logic crc);
    brs_pkg::brs_cmd_s c;
    brs_pkg::brs_env_s e;
    logic              ok, mine, rv;
    logic [15:0]       rd;
    logic [7:0]        s;
    c = '{1'b1, lng, en, crc, d, a, code};
    e = '0;
    {e.otp_program_enabled_flag, e.bus_switch_close_flag, e.internal_error} = 3'($urandom);
    e.holdup_uv = uv;
    ok   = crc && (!en || enh);
    mine = ok && a != 4'h0 && a == dev[3:0];
    rv   = 1'b0;
    rd   = 16'h0000;
    s    = {e.otp_program_enabled_flag, uv, 1'b0, e.bus_switch_close_flag, regf[1][1:0],
            e.internal_error, 1'b0};
    if (code == brs_pkg::CMD_SELFTEST_OFF && ok && (mine || a == 4'h0)) begin
      st   = 1'b0;
      rv   = mine;
      rd   = lng ? {a, 4'h0, s} : {8'h00, s};
      pend = (pend == 0) ? 1 : 2;
    end
    else if (mine && (code != brs_pkg::CMD_READ_REG || lng)) begin
      if (code == brs_pkg::CMD_READ_REG) rv = 1'b1;
      rd = {a, d[3:0], regf[d[3:0]]};
      if (code == brs_pkg::CMD_SELFTEST_ON && pend != 2) st = 1'b1;
      if (pend == 1) pend = 0;
    end
    @(posedge aclk);
    env <= e;
    i_mst.send(c);
    #1;
    chk(resp.valid, rv);
    if (rv) chk(resp.data, rd);
    if (rv) chk(resp.is_long, lng);
    chk(plate, st);
    chk(lock, pend == 2);
    // Held undervoltage clears the count at the next edge
    if (uv) pend = 0;
  endtask : dsi

  task automatic clr(input int k);
    brs_pkg::brs_env_s e;
    e    = '0;
    e[k] = 1'b1;
    @(posedge aclk);
    env <= e;
    @(posedge aclk);
    env <= '0;
    @(posedge aclk);
    #1;
    pend = 0;
    chk(lock, 1'b0);
  endtask : clr

  initial begin
    #500_000;
    errors++;
    close_out();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    env   = '0;
    {errors, checks, pend} = '0;
    {enh, st, uv} = '0;
    dev = 1;
    void'($urandom(32'h879e9ae9));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(brs_pkg::CTRL_OFF, brs_pkg::CTRL_RST, brs_pkg::RESP_OKAY);
    axr(brs_pkg::STAT_OFF, 32'h0000_0000, brs_pkg::RESP_OKAY);
    axr(8'h08, 32'h0000_0000, brs_pkg::RESP_SLVERR);
    axw(8'h08, 32'hFFFF_FFFF, brs_pkg::RESP_SLVERR);
    axw(brs_pkg::STAT_OFF, 32'h0000_0007, brs_pkg::RESP_OKAY);
    axr(brs_pkg::STAT_OFF, 32'h0000_0000, brs_pkg::RESP_OKAY);
    for (i = 0; i < 16; i++) begin
      w       = $urandom;
      regf[i] = w[7:0];
      axw(brs_pkg::REGF_BASE + 8'(4 * i), w, brs_pkg::RESP_OKAY);
    end
    axr(brs_pkg::REGF_BASE + 8'h04, {24'h0, regf[1]}, brs_pkg::RESP_OKAY);
    $display("test registers done");
    for (i = 0; i < 16; i++) dsi(brs_pkg::CMD_READ_REG, 4'h1, 8'(i), 1, 0, 1);
    dsi(brs_pkg::CMD_READ_REG, 4'h1, 8'h02, 0, 0, 1);
    dsi(brs_pkg::CMD_READ_REG, 4'h0, 8'h02, 1, 0, 1);
    dsi(brs_pkg::CMD_READ_REG, 4'h3, 8'h02, 1, 0, 1);
    dsi(brs_pkg::CMD_READ_REG, 4'h1, 8'h02, 1, 0, 0);
    dsi(brs_pkg::CMD_READ_REG, 4'h1, 8'h02, 1, 1, 1);
    $display("test register read done");
    dsi(brs_pkg::CMD_SELFTEST_ON, 4'h1, 8'($urandom), 0, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 1, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_ON, 4'h1, 8'($urandom), 1, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 0, 0, 1);
    dsi(brs_pkg::CMD_READ_REG, 4'h1, 8'h05, 1, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 1, 0, 1);
    axr(brs_pkg::STAT_OFF, stat(), brs_pkg::RESP_OKAY);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 0, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_ON, 4'h1, 8'($urandom), 1, 0, 1);
    axr(brs_pkg::STAT_OFF, stat(), brs_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 1, 0, 1);
      dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h0, 8'($urandom), 0, 0, 1);
      clr((k == 3) ? 5 : k);
      axr(brs_pkg::STAT_OFF, stat(), brs_pkg::RESP_OKAY);
    end
    uv = 1'b1;
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 1, 0, 1);
    uv = 1'b0;
    dsi(brs_pkg::CMD_SELFTEST_ON, 4'h1, 8'($urandom), 1, 0, 1);
    $display("test self-test and lockout done");
    axw(brs_pkg::CTRL_OFF, 32'hFFFF_FFF5, brs_pkg::RESP_OKAY);
    axr(brs_pkg::CTRL_OFF, 32'h0000_0015, brs_pkg::RESP_OKAY);
    dev = 5;
    enh = 1'b1;
    dsi(brs_pkg::CMD_READ_REG, 4'h5, 8'h07, 1, 1, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h5, 8'($urandom), 0, 1, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h1, 8'($urandom), 1, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h5, 8'($urandom), 1, 1, 1);
    axw(brs_pkg::CTRL_OFF, 32'h0000_0000, brs_pkg::RESP_OKAY);
    dev = 0;
    enh = 1'b0;
    clr(2);
    dsi(brs_pkg::CMD_SELFTEST_ON, 4'h0, 8'($urandom), 1, 0, 1);
    dsi(brs_pkg::CMD_SELFTEST_OFF, 4'h0, 8'($urandom), 1, 0, 1);
    $display("test enhanced framing and address done");
    close_out();
  end
endmodule : tb_bus_register_read_and_selftest_off
`default_nettype wire
